// ### verilog/pus_pkg.sv
package pus_pkg;

    // Configuration word placement and protected region
    localparam logic [13:0] CFG_WORD_ADDR   = 14'h2007;
    localparam logic [13:0] CFG_SPACE_LO    = 14'h2000;
    localparam logic [13:0] CFG_SPACE_HI    = 14'h3FFF;

    // Configuration word field positions
    localparam int          CFG_W           = 16;
    localparam int          BIT_WAKEUP_RST  = 12;
    localparam int          BIT_FAILSAFE    = 11;
    localparam int          BIT_SWITCHOVER  = 10;
    localparam int          BIT_BOR_HI      = 9;
    localparam int          BIT_BOR_LO      = 8;
    localparam int          BIT_DATA_PROT   = 7;
    localparam int          BIT_PROG_PROT   = 6;
    localparam int          BIT_EXT_RST_EN  = 5;
    localparam int          BIT_POWER_UP_DELAY_TIMER_EN     = 4;
    localparam int          BIT_WDOG_EN     = 3;
    localparam int          BIT_OSC_HI      = 2;
    localparam int          BIT_OSC_LO      = 0;

    // Erased word and bits that always read as one
    localparam logic [15:0] CFG_RESET       = 16'hFFFF;
    localparam logic [15:0] CFG_UNIMPL_MASK = 16'hE000;

    // Oscillator select codes
    localparam logic [2:0]  OSC_LP          = 3'h0;
    localparam logic [2:0]  OSC_CRYSTAL_MAX = 3'h2;
    localparam logic [2:0]  OSC_INTERNAL_OSCILLATOR_OPTION_A    = 3'h4;
    localparam logic [2:0]  OSC_INTERNAL_OSCILLATOR_OPTION_B    = 3'h5;

    // Brown-out select code meaning disabled
    localparam logic [1:0]  BOR_OFF         = 2'h0;

    // Timing
    localparam int          CLK_KHZ         = 40000;
    localparam int          POWER_UP_DELAY_TIMER_MS         = 64;
    localparam int          POWER_UP_DELAY_TIMER_CYCLES     = POWER_UP_DELAY_TIMER_MS * CLK_KHZ;
    localparam int          POWER_UP_DELAY_TIMER_CNT_W      = 22;
    localparam int          OST_OSC_CYCLES  = 1024;
    localparam int          OST_CNT_W       = 11;

    // Sequencer states, Gray along the start-up path
    typedef enum logic [2:0] {
        PUS_HOLD  = 3'b000,
        PUS_POWER_UP_DELAY_TIMER  = 3'b001,
        PUS_OST   = 3'b011,
        PUS_RUN   = 3'b010,
        PUS_SLEEP = 3'b110
    } pus_state_t;

endpackage : pus_pkg

// ### verilog/pus_delay_cnt.sv
`timescale 1ns/100ps
module pus_delay_cnt #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic         ce_i,
    // Control
    input  wire logic         start_i,
    input  wire logic         abort_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] load_i,
    // Status
    output logic              busy_o,
    output logic              done_o
);

    logic [W-1:0] cnt_r;
    logic         busy_r;
    logic         last_w;

    // Zero load behaves as one tick so done always fires
    assign last_w = (cnt_r <= {{(W-1){1'b0}}, 1'b1});
    assign done_o = busy_r & tick_i & last_w & ~abort_i;
    assign busy_o = busy_r;

    // Down counter, advanced only on ticks
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
        end else if (ce_i) begin
            if (abort_i) begin
                busy_r <= 1'b0;
            end else if (start_i) begin
                cnt_r  <= load_i;
                busy_r <= 1'b1;
            end else if (busy_r && tick_i) begin
                cnt_r  <= cnt_r - {{(W-1){1'b0}}, 1'b1};
                busy_r <= ~last_w;
            end
        end
    end

endmodule : pus_delay_cnt

// ### verilog/pus_sequencer.sv
// Operation
// - The power-up delay holds reset for a nominal 64 ms, applied after power-up and after a brown-out.
// - The oscillator start-up delay holds reset until the crystal has run a set number of cycles; on a continuing wake the code keeps reset released.
// - A detected brown-out forces the device into reset.
// - After a brown-out the power-up delay stretches the reset when that delay is enabled.
// - Sleep ends on an external reset, a watchdog wake-up or an interrupt.
// - Configuration bits read 0 when programmed and 1 when unprogrammed, selecting options.
// - The configuration word sits at program address 2007h.
// - The region 2000h to 3FFFh is reachable only in programming mode.
// - Configuration bits select the internal oscillator or the low-power crystal option.
`timescale 1ns/100ps
module pus_sequencer
    import pus_pkg::*;
#(
    parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES_P = POWER_UP_DELAY_TIMER_CYCLES,
    parameter int unsigned OST_CYCLES_P  = OST_OSC_CYCLES
) (
    // Clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire logic              ce_i,
    // Asynchronous pins and analog events
    input  wire logic              brownout_detect_i,
    input  wire logic              ext_reset_pin_n_i,
    input  wire logic              osc_crystal_clk_i,
    input  wire logic              watchdog_timer_wake_i,
    input  wire logic              irq_wake_i,
    input  wire logic              prog_mode_i,
    // Core requests, same clock
    input  wire logic              sleep_req_i,
    // Programming port
    input  wire logic [13:0]       prog_addr_i,
    input  wire logic              prog_wr_i,
    input  wire logic              prog_erase_i,
    input  wire logic [CFG_W-1:0]  prog_wdata_i,
    output logic      [CFG_W-1:0]  prog_rdata_o,
    // Reset and power state
    output logic                   core_reset_n_o,
    output logic                   sleep_o,
    output logic [2:0]             seq_state_o,
    // Decoded configuration options
    output logic                   internal_oscillator_option_o,
    output logic                   low_power_crystal_option_o,
    output logic                   watchdog_enable_o,
    output logic                   brownout_reset_enable_o,
    output logic                   external_reset_pin_enable_o,
    output logic                   failsafe_clock_monitor_enable_o,
    output logic                   internal_external_switchover_o,
    output logic                   program_memory_protect_o,
    output logic                   data_memory_protect_o
);

    localparam int NSYNC = 6;

    // Programmed bit reads 0, so an option is on when its bit is 0
    function automatic logic cfg_on(input logic b);
        cfg_on = ~b;
    endfunction : cfg_on

    // Address lies in the protected configuration space
    function automatic logic in_cfg_space(input logic [13:0] a);
        in_cfg_space = (a >= CFG_SPACE_LO) && (a <= CFG_SPACE_HI);
    endfunction : in_cfg_space

    // Two-flop synchronisers for every pin-side input
    logic [NSYNC-1:0] async_w;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;

    assign async_w = {prog_mode_i, irq_wake_i, watchdog_timer_wake_i,
                      osc_crystal_clk_i, ext_reset_pin_n_i, brownout_detect_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else if (ce_i) begin
                    sync1_r[gi] <= async_w[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    logic bor_s;
    logic ext_rst_n_s;
    logic osc_s;
    logic wdt_s;
    logic irq_s;
    logic prog_s;
    logic osc_d_r;

    assign bor_s       = sync2_r[0];
    assign ext_rst_n_s = sync2_r[1];
    assign osc_s       = sync2_r[2];
    assign wdt_s       = sync2_r[3];
    assign irq_s       = sync2_r[4];
    assign prog_s      = sync2_r[5];

    // Configuration word storage, erased state is all ones
    logic [CFG_W-1:0] cfg_r;
    logic [CFG_W-1:0] rdata_r;
    logic             acc_ok_w;
    logic             cfg_hit_w;

    assign acc_ok_w  = prog_s & in_cfg_space(prog_addr_i);
    assign cfg_hit_w = acc_ok_w & (prog_addr_i == CFG_WORD_ADDR);

    // Programming only clears bits; erase restores ones
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_r   <= CFG_RESET;
            rdata_r <= '0;
        end else if (ce_i) begin
            if (cfg_hit_w && prog_erase_i) begin
                cfg_r <= CFG_RESET;
            end else if (cfg_hit_w && prog_wr_i) begin
                cfg_r <= (cfg_r & prog_wdata_i) | CFG_UNIMPL_MASK;
            end
            rdata_r <= cfg_hit_w ? cfg_r : '0;
        end
    end

    assign prog_rdata_o = rdata_r;

    // Option decode
    logic [2:0] osc_sel_w;
    logic       crystal_w;
    logic       power_up_delay_timer_en_w;
    logic       bor_en_w;
    logic       mclr_en_w;
    logic       wake_cont_w;

    assign osc_sel_w   = cfg_r[BIT_OSC_HI:BIT_OSC_LO];
    assign crystal_w   = (osc_sel_w <= OSC_CRYSTAL_MAX);
    assign power_up_delay_timer_en_w   = cfg_on(cfg_r[BIT_POWER_UP_DELAY_TIMER_EN]);
    assign bor_en_w    = (cfg_r[BIT_BOR_HI:BIT_BOR_LO] != BOR_OFF);
    assign mclr_en_w   = cfg_r[BIT_EXT_RST_EN];
    assign wake_cont_w = cfg_r[BIT_WAKEUP_RST];

    // Options decoded straight from the stored word, so they follow every write
    assign internal_oscillator_option_o    = (osc_sel_w == OSC_INTERNAL_OSCILLATOR_OPTION_A) ||
                                             (osc_sel_w == OSC_INTERNAL_OSCILLATOR_OPTION_B);
    assign low_power_crystal_option_o      = (osc_sel_w == OSC_LP);
    assign watchdog_enable_o               = cfg_r[BIT_WDOG_EN];
    assign brownout_reset_enable_o         = bor_en_w;
    assign external_reset_pin_enable_o     = mclr_en_w;
    assign failsafe_clock_monitor_enable_o = cfg_r[BIT_FAILSAFE];
    assign internal_external_switchover_o  = cfg_r[BIT_SWITCHOVER];
    assign program_memory_protect_o        = cfg_on(cfg_r[BIT_PROG_PROT]);
    assign data_memory_protect_o           = cfg_on(cfg_r[BIT_DATA_PROT]);

    // Reset causes and wake events
    logic bor_act_w;
    logic ext_act_w;
    logic force_w;
    logic wake_w;
    logic osc_tick_w;

    assign bor_act_w  = bor_en_w & bor_s;
    assign ext_act_w  = mclr_en_w & ~ext_rst_n_s;
    assign force_w    = bor_act_w | ext_act_w;
    assign wake_w     = wdt_s | irq_s;
    assign osc_tick_w = osc_s & ~osc_d_r;

    // Sequencer
    pus_state_t state_r;
    pus_state_t state_nxt;
    logic       power_up_delay_timer_pend_r;
    logic       cont_r;
    logic       cont_nxt;
    logic       core_rst_n_r;
    logic       core_rst_n_nxt;
    logic       power_up_delay_timer_start_w;
    logic       ost_start_w;
    logic       power_up_delay_timer_done_w;
    logic       ost_done_w;

    always_comb begin
        state_nxt    = state_r;
        cont_nxt     = cont_r;
        power_up_delay_timer_start_w = 1'b0;
        ost_start_w  = 1'b0;
        if (force_w) begin
            state_nxt = PUS_HOLD;
            cont_nxt  = 1'b0;
        end else begin
            case (state_r)
                PUS_HOLD: begin
                    if (power_up_delay_timer_pend_r && power_up_delay_timer_en_w) begin
                        state_nxt    = PUS_POWER_UP_DELAY_TIMER;
                        power_up_delay_timer_start_w = 1'b1;
                    end else if (crystal_w) begin
                        state_nxt   = PUS_OST;
                        ost_start_w = 1'b1;
                    end else begin
                        state_nxt = PUS_RUN;
                    end
                end
                PUS_POWER_UP_DELAY_TIMER: begin
                    if (power_up_delay_timer_done_w && crystal_w) begin
                        state_nxt   = PUS_OST;
                        ost_start_w = 1'b1;
                    end else if (power_up_delay_timer_done_w) begin
                        state_nxt = PUS_RUN;
                    end
                end
                PUS_OST: begin
                    if (ost_done_w) begin
                        state_nxt = PUS_RUN;
                        cont_nxt  = 1'b0;
                    end
                end
                PUS_RUN: begin
                    if (sleep_req_i) begin
                        state_nxt = PUS_SLEEP;
                    end
                end
                PUS_SLEEP: begin
                    if (wake_w && !wake_cont_w) begin
                        state_nxt = PUS_HOLD;
                    end else if (wake_w && crystal_w) begin
                        state_nxt   = PUS_OST;
                        ost_start_w = 1'b1;
                        cont_nxt    = 1'b1;
                    end else if (wake_w) begin
                        state_nxt = PUS_RUN;
                    end
                end
                default: begin
                    state_nxt = PUS_HOLD;
                end
            endcase
        end
        // Reset stays on until the path reaches run, except a continuing wake
        core_rst_n_nxt = (state_nxt == PUS_RUN) || (state_nxt == PUS_SLEEP) ||
                         ((state_nxt == PUS_OST) && cont_nxt);
    end

    // State registers; power-up delay owed after power-on
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r      <= PUS_HOLD;
            power_up_delay_timer_pend_r  <= 1'b1;
            cont_r       <= 1'b0;
            core_rst_n_r <= 1'b0;
            osc_d_r      <= 1'b0;
        end else if (ce_i) begin
            state_r      <= state_nxt;
            cont_r       <= cont_nxt;
            core_rst_n_r <= core_rst_n_nxt;
            osc_d_r      <= osc_s;
            if (bor_act_w) begin
                power_up_delay_timer_pend_r <= 1'b1;
            end else if (state_r == PUS_HOLD && !force_w) begin
                power_up_delay_timer_pend_r <= 1'b0;
            end
        end
    end

    assign core_reset_n_o = core_rst_n_r;
    assign sleep_o        = (state_r == PUS_SLEEP);
    assign seq_state_o    = state_r;

    // Power-up delay counts system clocks
    pus_delay_cnt #(
        .W        (POWER_UP_DELAY_TIMER_CNT_W)
    ) u_power_up_delay_timer (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .start_i  (power_up_delay_timer_start_w),
        .abort_i  (force_w),
        .tick_i   (1'b1),
        .load_i   (POWER_UP_DELAY_TIMER_CNT_W'(POWER_UP_DELAY_TIMER_CYCLES_P)),
        .busy_o   (),
        .done_o   (power_up_delay_timer_done_w)
    );

    // Start-up delay counts crystal edges, so a dead crystal never releases reset
    pus_delay_cnt #(
        .W        (OST_CNT_W)
    ) u_ost (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .start_i  (ost_start_w),
        .abort_i  (force_w),
        .tick_i   (osc_tick_w),
        .load_i   (OST_CNT_W'(OST_CYCLES_P)),
        .busy_o   (),
        .done_o   (ost_done_w)
    );

endmodule : pus_sequencer

// ### tb/pus_chk.sv
`timescale 1ns/100ps
module pus_chk
    import pus_pkg::*;
#(
    parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES_P = POWER_UP_DELAY_TIMER_CYCLES,
    parameter int unsigned OST_CYCLES_P  = OST_OSC_CYCLES
) (
    // Clock and reset
    input wire logic             clk_i,
    input wire logic             resetn_i,
    input wire logic             ce_i,
    // Events and programming
    input wire logic             brownout_detect_i,
    input wire logic             osc_crystal_clk_i,
    input wire logic             watchdog_timer_wake_i,
    input wire logic             irq_wake_i,
    input wire logic             prog_mode_i,
    input wire logic [13:0]      prog_addr_i,
    // Watched outputs
    input wire logic [CFG_W-1:0] prog_rdata_o,
    input wire logic             core_reset_n_o,
    input wire logic             sleep_o,
    input wire logic [2:0]       seq_state_o,
    input wire logic             low_power_crystal_option_o,
    input wire logic             brownout_reset_enable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    int unsigned power_up_delay_timer_cnt_r;
    int unsigned xtal_cnt_r;
    logic        xtal_q_r;
    wire         xtal_rise = osc_crystal_clk_i & ~xtal_q_r;

    // Cycles spent in the power-up delay, raw crystal edges seen in start-up
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            power_up_delay_timer_cnt_r <= 0;
            xtal_cnt_r <= 0;
            xtal_q_r   <= 1'b0;
        end else begin
            xtal_q_r   <= osc_crystal_clk_i;
            power_up_delay_timer_cnt_r <= (seq_state_o != PUS_POWER_UP_DELAY_TIMER) ? 0 : power_up_delay_timer_cnt_r + (ce_i ? 1 : 0);
            xtal_cnt_r <= (seq_state_o != PUS_OST) ? 0 : xtal_cnt_r + (xtal_rise ? 1 : 0);
        end
    end

    property p_release;
        $rose(core_reset_n_o) |-> seq_state_o == PUS_RUN || $past(seq_state_o) == PUS_RUN;
    endproperty
    a_release: assert property (p_release) else $error("core released outside run");
    property p_power_up_delay_timer_hold;
        seq_state_o == PUS_POWER_UP_DELAY_TIMER && $past(seq_state_o) == PUS_POWER_UP_DELAY_TIMER |-> !core_reset_n_o;
    endproperty
    a_power_up_delay_timer_hold: assert property (p_power_up_delay_timer_hold) else $error("reset not held in delay");
    property p_power_up_delay_timer_len;
        seq_state_o == PUS_POWER_UP_DELAY_TIMER ##1 seq_state_o inside {PUS_OST, PUS_RUN}
            |-> power_up_delay_timer_cnt_r >= POWER_UP_DELAY_TIMER_CYCLES_P - 1 && power_up_delay_timer_cnt_r <= POWER_UP_DELAY_TIMER_CYCLES_P + 1;
    endproperty
    a_power_up_delay_timer_len: assert property (p_power_up_delay_timer_len) else $error("power-up delay length wrong");
    property p_ost_len;
        seq_state_o == PUS_OST ##1 seq_state_o == PUS_RUN |-> xtal_cnt_r >= OST_CYCLES_P - 1;
    endproperty
    a_ost_len: assert property (p_ost_len) else $error("crystal start-up too short");
    property p_brownout;
        (brownout_reset_enable_o && brownout_detect_i) [*5] |-> !core_reset_n_o;
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out gave no reset");
    property p_wake;
        (sleep_o && (irq_wake_i || watchdog_timer_wake_i)) [*2] |-> ##[0:3] !sleep_o;
    endproperty
    a_wake: assert property (p_wake) else $error("sleep not left on wake");
    property p_prog_only;
        !prog_mode_i [*4] |-> prog_rdata_o == 16'h0000;
    endproperty
    a_prog_only: assert property (p_prog_only) else $error("read outside programming");
    property p_addr;
        (ce_i && prog_addr_i != CFG_WORD_ADDR) [*2] |-> prog_rdata_o == 16'h0000;
    endproperty
    a_addr: assert property (p_addr) else $error("word seen at wrong address");
    property p_ones;
        prog_rdata_o != 16'h0000 |-> prog_rdata_o[15:13] == 3'b111;
    endproperty
    a_ones: assert property (p_ones) else $error("unused bits not one");
    property p_osc_path;
        seq_state_o == PUS_RUN && $past(seq_state_o) inside {PUS_HOLD, PUS_POWER_UP_DELAY_TIMER}
            |-> !low_power_crystal_option_o;
    endproperty
    a_osc_path: assert property (p_osc_path) else $error("crystal start-up skipped");
endmodule : pus_chk

bind pus_sequencer pus_chk #(.POWER_UP_DELAY_TIMER_CYCLES_P(POWER_UP_DELAY_TIMER_CYCLES_P), .OST_CYCLES_P(OST_CYCLES_P)) u_chk (
    .clk_i, .resetn_i, .ce_i, .brownout_detect_i, .osc_crystal_clk_i, .watchdog_timer_wake_i,
    .irq_wake_i, .prog_mode_i, .prog_addr_i, .prog_rdata_o, .core_reset_n_o, .sleep_o,
    .seq_state_o, .low_power_crystal_option_o, .brownout_reset_enable_o);

// ### tb/pus_sequencer_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); end end
module pus_sequencer_test;
    import pus_pkg::*;
    localparam int unsigned PW = 20;
    localparam int unsigned OS = 4;
    // Inputs
    logic clk_i = 1'b0, resetn_i, ce_i, brownout_detect_i, ext_reset_pin_n_i;
    logic osc_crystal_clk_i = 1'b0, watchdog_timer_wake_i, irq_wake_i, prog_mode_i;
    logic sleep_req_i, prog_wr_i, prog_erase_i;
    logic [13:0] prog_addr_i;
    logic [15:0] prog_wdata_i, prog_rdata_o, cfg_exp;
    // Outputs
    logic core_reset_n_o, sleep_o, internal_oscillator_option_o, low_power_crystal_option_o;
    logic watchdog_enable_o, brownout_reset_enable_o, external_reset_pin_enable_o;
    logic failsafe_clock_monitor_enable_o, internal_external_switchover_o;
    logic program_memory_protect_o, data_memory_protect_o;
    logic [2:0] seq_state_o;
    int err_total = 0, check_count = 0, n, xdiv = 0;
    wire [8:0] opt_w = {internal_oscillator_option_o, low_power_crystal_option_o,
        watchdog_enable_o, brownout_reset_enable_o, external_reset_pin_enable_o,
        failsafe_clock_monitor_enable_o, internal_external_switchover_o,
        program_memory_protect_o, data_memory_protect_o};

    pus_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES_P(PW), .OST_CYCLES_P(OS)) DUT (.clk_i, .resetn_i, .ce_i,
        .brownout_detect_i, .ext_reset_pin_n_i, .osc_crystal_clk_i, .watchdog_timer_wake_i,
        .irq_wake_i, .prog_mode_i, .sleep_req_i, .prog_addr_i, .prog_wr_i, .prog_erase_i,
        .prog_wdata_i, .prog_rdata_o, .core_reset_n_o, .sleep_o, .seq_state_o,
        .internal_oscillator_option_o, .low_power_crystal_option_o, .watchdog_enable_o,
        .brownout_reset_enable_o, .external_reset_pin_enable_o,
        .failsafe_clock_monitor_enable_o, .internal_external_switchover_o,
        .program_memory_protect_o, .data_memory_protect_o);

    initial forever #12.5 clk_i = ~clk_i;
    // Crystal runs free, one period every six system cycles
    always @(posedge clk_i) begin
        #2;
        xdiv = (xdiv == 5) ? 0 : xdiv + 1;
        osc_crystal_clk_i = (xdiv < 3);
    end

    function automatic logic [8:0] exp_opts(logic [15:0] c);
        return {c[2:0] == 3'h4 || c[2:0] == 3'h5, c[2:0] == 3'h0, c[3], c[9:8] != 2'h0,
            c[5], c[11], c[10], ~c[6], ~c[7]};
    endfunction : exp_opts

    task automatic cyc(int k);
        repeat (k) @(posedge clk_i);
        #2;
    endtask : cyc

    // One programming-port access, then a read of the same address
    task automatic prog(logic [13:0] a, logic w, logic e, logic [15:0] d);
        logic hit;
        hit = prog_mode_i && a == CFG_WORD_ADDR;
        prog_addr_i = a;
        prog_wr_i = w;
        prog_erase_i = e;
        prog_wdata_i = d;
        cyc(1);
        prog_wr_i = 1'b0;
        prog_erase_i = 1'b0;
        if (hit && e) cfg_exp = 16'hFFFF;
        else if (hit && w) cfg_exp = (cfg_exp & d) | CFG_UNIMPL_MASK;
        cyc(1);
        `CHK(prog_rdata_o, hit ? cfg_exp : 16'h0000)
        `CHK(opt_w, exp_opts(cfg_exp))
    endtask : prog

    // Bounded wait for the core to run again
    task automatic wait_run(output int c);
        c = 0;
        while (!(core_reset_n_o === 1'b1 && seq_state_o === 3'b010) && c < 400) begin
            cyc(1);
            c++;
        end
        if (c >= 400) `CHK(1'b0, 1'b1)
    endtask : wait_run

    // Brown-out or pin reset, then time to release
    task automatic rst_run(bit bo, output int c);
        if (bo) brownout_detect_i = 1'b1;
        else ext_reset_pin_n_i = 1'b0;
        cyc(6);
        `CHK(core_reset_n_o, 1'b0)
        brownout_detect_i = 1'b0;
        ext_reset_pin_n_i = 1'b1;
        wait_run(c);
    endtask : rst_run

    task automatic give_verdict;
        $display("Mismatches %0d, comparisons %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    initial begin
        #500000;
        err_total++;
        give_verdict();
    end

    initial begin
        {resetn_i, brownout_detect_i, watchdog_timer_wake_i, irq_wake_i} = 4'h0;
        {prog_mode_i, sleep_req_i, prog_wr_i, prog_erase_i} = 4'h0;
        {ce_i, ext_reset_pin_n_i} = 2'h3;
        prog_addr_i = 14'h0000;
        prog_wdata_i = 16'h0000;
        cfg_exp = 16'hFFFF;
        void'($urandom(32'h2d81));
        cyc(16);
        resetn_i = 1'b1;
        wait_run(n);
        `CHK(n < PW, 1'b1)
        prog(CFG_WORD_ADDR, 1'b1, 1'b0, 16'h0000);
        prog_mode_i = 1'b1;
        cyc(4);
        prog(CFG_WORD_ADDR, 1'b0, 1'b0, 16'h0000);
        prog(14'h2006, 1'b1, 1'b0, 16'h0000);
        // Random accesses, half aimed at the word
        repeat (24) prog(($urandom % 2) ? CFG_WORD_ADDR : 14'($urandom % 16384),
            1'($urandom), ($urandom % 8) == 0, 16'($urandom));
        prog(CFG_WORD_ADDR, 1'b0, 1'b1, 16'h0000);
        prog(CFG_WORD_ADDR, 1'b1, 1'b0, 16'hFFEC);
        prog_mode_i = 1'b0;
        cyc(4);
        `CHK(prog_rdata_o, 16'h0000)
        rst_run(1'b1, n);
        `CHK(n >= PW && n <= PW + 8, 1'b1)
        rst_run(1'b0, n);
        `CHK(n < PW, 1'b1)
        prog_mode_i = 1'b1;
        cyc(4);
        prog(CFG_WORD_ADDR, 1'b1, 1'b0, 16'hFFE8);
        prog_mode_i = 1'b0;
        cyc(4);
        rst_run(1'b1, n);
        `CHK(n >= PW + 6 * (OS - 1) && n <= PW + 6 * OS + 14, 1'b1)
        // Sleep, then each wake source; the last pass clears continue, so wake resets
        for (int k = 0; k < 4; k++) begin
            if (k == 3) begin
                prog_mode_i = 1'b1;
                cyc(4);
                prog(CFG_WORD_ADDR, 1'b1, 1'b0, 16'hEFE8);
                prog_mode_i = 1'b0;
                cyc(4);
            end
            sleep_req_i = 1'b1;
            cyc(1);
            sleep_req_i = 1'b0;
            cyc(1);
            `CHK(sleep_o, 1'b1)
            irq_wake_i = (k == 0) || (k == 3);
            watchdog_timer_wake_i = (k == 1);
            ext_reset_pin_n_i = (k != 2);
            cyc(5);
            `CHK(sleep_o, 1'b0)
            if (k < 2) `CHK(core_reset_n_o, 1'b1)
            else `CHK(core_reset_n_o, 1'b0)
            {irq_wake_i, watchdog_timer_wake_i, ext_reset_pin_n_i} = 3'b001;
            wait_run(n);
        end
        give_verdict();
    end
endmodule : pus_sequencer_test
